// [dv/ilg_adc_model.sv]
// Behavioural converter pair that feeds the sample ports and their port clocks.
`timescale 1ns/100ps

module ilg_adc_model
  import ilg_pkg::*;
(
  input  wire logic                        clk,
  output logic                             port_ab_clock,
  output logic                             port_cd_clock,
  output logic [NPORT-1:0][MANT_W-1:0]     mantissa,
  output logic [NPORT-1:0][EXP_W-1:0]      exponent,
  output logic [NPORT-1:0]                 input_qualifier
);
  initial begin
    port_ab_clock = 1'b0;
    port_cd_clock = 1'b0;
    mantissa = '0;
    exponent = '0;
    input_qualifier = '0;
  end

  // One sample on a port pair; data is stable four cycles before the clock rise and eight after, then garbled.
  task automatic send(input logic cd, input logic [1:0][MANT_W-1:0] m, input logic [1:0][EXP_W-1:0] e,
                      input logic [1:0] q);
    int b;
    b = cd ? 2 : 0;
    @(posedge clk);
    mantissa[b +: 2] <= m;
    exponent[b +: 2] <= e;
    input_qualifier[b +: 2] <= q;
    repeat (4) @(posedge clk);
    if (cd) port_cd_clock <= 1'b1;
    else port_ab_clock <= 1'b1;
    repeat (4) @(posedge clk);
    port_ab_clock <= 1'b0;
    port_cd_clock <= 1'b0;
    repeat (4) @(posedge clk);
    mantissa[b +: 2] <= ~m;
    exponent[b +: 2] <= ~e;
    input_qualifier[b +: 2] <= ~q;
  endtask
endmodule // ilg_adc_model

// [dv/ilg_gain_switch_properties.sv]
// Port-level checker for the input level gain switch, bound to the design.
`timescale 1ns/100ps

module ilg_gain_switch_checker
  import ilg_pkg::*;
#(
  parameter int DWELL_W = 16,
  parameter int OUT_W   = 24
) (
  input wire logic                         clk,
  input wire logic                         nrst,
  input wire logic                         ce,
  input wire logic                         port_ab_clock,
  input wire logic                         port_cd_clock,
  input wire logic [ADDR_W-1:0]            reg_addr,
  input wire logic [DATA_W-1:0]            reg_wdata,
  input wire logic                         reg_write,
  input wire logic                         reg_read,
  input wire logic [DATA_W-1:0]            reg_rdata,
  input wire logic [NPORT-1:0]             level_flag_primary,
  input wire logic [NPORT-1:0]             level_flag_secondary,
  input wire logic [NPORT-1:0][OUT_W-1:0]  scaled_data,
  input wire logic [NPORT-1:0]             scaled_valid
);
  logic [NPORT-1:0]     ilv_q;
  logic [2*SCALE_W-1:0] sc0_q;

  // Shadow of each port's interleave bit, so the complement rule is only held where it applies.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ilv_q <= '0;
    else if (ce && reg_write && reg_addr[7:0] == OFF_CTRL) ilv_q[reg_addr[9:8]] <= reg_wdata[CTRL_ILV_BIT];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) sc0_q <= RST_SCALE;
    else if (ce && reg_write && reg_addr == {2'b00, OFF_SCALE}) sc0_q <= reg_wdata[9:0];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_sec_complement: assert property (
    ((level_flag_secondary ^ ~level_flag_primary) & ~(ilv_q | $past(ilv_q) | $past(ilv_q, 2))) == '0)
    else $error("secondary flag is not the complement of primary");
  a_read_idle: assert property ($past(ce && !reg_read) |-> reg_rdata == '0)
    else $error("read data not zero outside a read answer");
  a_scale_read: assert property (
    $past(reg_read && ce && reg_addr == {2'b00, OFF_SCALE}) |-> reg_rdata == {22'h000000, sc0_q})
    else $error("scale register read back wrong");
  a_valid_single: assert property ((scaled_valid & $past(scaled_valid)) == '0)
    else $error("sample valid longer than one cycle");
  a_ab_strobe: assert property ($rose(port_ab_clock) |-> ##[3:5] (scaled_valid[1:0] == 2'b11))
    else $error("ports 0 and 1 gave no sample after their clock");
  a_cd_strobe: assert property ($rose(port_cd_clock) |-> ##[3:5] (scaled_valid[3:2] == 2'b11))
    else $error("ports 2 and 3 gave no sample after their clock");
  a_ab_domain: assert property ((scaled_valid[1:0] != 2'b00) |-> $past(port_ab_clock, 3))
    else $error("ports 0 and 1 sampled without their clock");
  a_flag_on_sample: assert property (
    ((level_flag_primary ^ $past(level_flag_primary)) & ~$past(scaled_valid)) == '0)
    else $error("primary flag moved without a sample");
  a_data_hold: assert property ((scaled_valid == '0) |-> $stable(scaled_data))
    else $error("scaled data changed without a sample");
endmodule // ilg_gain_switch_checker

bind ilg_gain_switch ilg_gain_switch_checker #(.DWELL_W(DWELL_W), .OUT_W(OUT_W)) u_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .port_ab_clock(port_ab_clock), .port_cd_clock(port_cd_clock),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .level_flag_primary(level_flag_primary),
  .level_flag_secondary(level_flag_secondary), .scaled_data(scaled_data), .scaled_valid(scaled_valid));

// [dv/ilg_gain_switch_tb.sv]
// Self-checking bench for the input level gain switch.
`timescale 1ns/100ps

module ilg_gain_switch_tb
  import ilg_pkg::*;
;
  logic                        clk = 1'b0;
  logic                        nrst = 1'b0;
  logic                        ce = 1'b1;
  logic [ADDR_W-1:0]           reg_addr = '0;
  logic [DATA_W-1:0]           reg_wdata = '0;
  logic [DATA_W-1:0]           reg_rdata;
  logic                        reg_write = 1'b0;
  logic                        reg_read = 1'b0;
  logic                        port_ab_clock;
  logic                        port_cd_clock;
  logic [NPORT-1:0][MANT_W-1:0] mantissa;
  logic [NPORT-1:0][EXP_W-1:0]  exponent;
  logic [NPORT-1:0]            input_qualifier;
  logic [NPORT-1:0]            level_flag_primary;
  logic [NPORT-1:0]            level_flag_secondary;
  logic [NPORT-1:0]            scaled_valid;
  logic [NPORT-1:0][23:0]      scaled_data;
  int                          n_errors = 0;
  int                          checks = 0;

  ilg_gain_switch dut (.clk, .nrst, .ce, .port_ab_clock, .port_cd_clock, .mantissa, .exponent,
    .input_qualifier, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .level_flag_primary,
    .level_flag_secondary, .scaled_data, .scaled_valid);
  ilg_adc_model adc (.clk, .port_ab_clock, .port_cd_clock, .mantissa, .exponent, .input_qualifier);

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask

  // Expected output: mantissa widened by ten fraction bits, then arithmetic shift right.
  function automatic logic [23:0] scl(input logic [13:0] m, input int sh);
    logic signed [23:0] v;
    v = {m, 10'h000};
    return v >>> sh;
  endfunction

  task automatic hs(input logic [13:0] m, input logic f);
    adc.send(1'b0, {14'h0000, m}, '0, '0);
    chk("flag_p0", 32'(f), 32'(level_flag_primary[0]));
    chk("data_p0", 32'(scl(m, 0)), 32'(scaled_data[0]));
  endtask

  task automatic ss(input logic [13:0] m, input int sh);
    adc.send(1'b0, {m, 14'h0000}, {3'h5, 3'h0}, '0);
    chk("data_p1", 32'(scl(m, sh)), 32'(scaled_data[1]));
  endtask

  task automatic ci(input logic [13:0] m, input logic q, input logic [1:0] f);
    adc.send(1'b1, {14'h0000, m}, '0, {1'b0, q});
    chk("flags_p2", 32'(f), 32'({level_flag_secondary[2], level_flag_primary[2]}));
    chk("sec_p3", 32'h1, 32'(level_flag_secondary[3]));
  endtask

  task automatic t_regs();
    rd(10'h092, 32'h0, "scale_reset");
    rd(10'h094, 32'h3FFF, "upper_reset");
    rd(10'h096, 32'h0, "dwell_reset");
    wr(10'h392, 32'hFFFFFFFF);
    rd(10'h392, 32'h3FF, "scale_width");
    wr(10'h3F0, 32'h1);
    rd(10'h3F0, 32'h0, "unmapped");
    wr(10'h092, 32'h2A5);
    rd(10'h092, 32'h2A5, "scale_p0");
    @(posedge clk);
    ce <= 1'b0;
    wr(10'h092, 32'h0);
    ce <= 1'b1;
    rd(10'h092, 32'h2A5, "ce_freeze");
    wr(10'h092, 32'h0);
  endtask

  task automatic t_hyst();
    wr(10'h094, 32'h3E8);
    wr(10'h095, 32'h1F4);
    wr(10'h096, 32'h3);
    hs(14'h3E7, 1'b0);
    hs(14'h3C18, 1'b1);
    hs(14'h320, 1'b1);
    hs(14'h190, 1'b1);
    hs(14'h190, 1'b1);
    rd(10'h09A, 32'h2, "status_dwell");
    hs(14'h258, 1'b1);
    hs(14'h190, 1'b1);
    hs(14'h190, 1'b1);
    hs(14'h190, 1'b0);
    adc.send(1'b0, {14'h0000, 14'h100}, {3'h0, 3'h3}, '0);
    chk("exp_right", 32'(scl(14'h100, 3)), 32'(scaled_data[0]));
  endtask

  task automatic t_scale();
    wr(10'h193, 32'h9);
    wr(10'h192, 32'h5E);
    wr(10'h194, 32'h3E8);
    wr(10'h195, 32'h1F4);
    wr(10'h196, 32'h1);
    ss(14'h064, 4);
    ss(14'h7D0, 4);
    chk("flag_p1", 32'h1, 32'(level_flag_primary[1]));
    ss(14'h064, 4);
    ss(14'h064, 4);
    ss(14'h064, 0);
    ss(14'h064, 4);
  endtask

  task automatic t_ilv();
    wr(10'h293, 32'h2);
    wr(10'h294, 32'h3E8);
    wr(10'h297, 32'h3E8);
    wr(10'h298, 32'h1F4);
    wr(10'h299, 32'h1);
    ci(14'h7D0, 1'b1, 2'b10);
    ci(14'h7D0, 1'b0, 2'b11);
    ci(14'h064, 1'b1, 2'b01);
    rd(10'h29A, 32'h1, "status_ilv");
  endtask

  task automatic t_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1 chk("prim_rst", 32'h0, 32'(level_flag_primary));
    chk("sec_rst", 32'hF, 32'(level_flag_secondary));
    rd(10'h192, 32'h0, "scale_rst");
    ss(14'h7D0, 5);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_hyst();
    t_scale();
    t_ilv();
    t_reset();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule // ilg_gain_switch_tb

// [verilog/ilg_gain_switch.sv]
// Level detection, dwell hysteresis and exponent scaling for four input ports.
//
// What this block does
// - Indicator sets when sample reaches upper threshold.
// - Indicator holds until input drops below lower.
// - Below lower starts dwell count before release.
// - Rising above lower resets the dwell count.
// - Dwell counts down; release at zero.
// - Quiet scale bits 9:5, loud 4:0.
// - Eight circuits; interleave drives secondary indicator.
// - Primary watches qualifier low, secondary high.
// - No interleave: secondary is primary's complement.
// - Thresholds compare raw unfiltered input samples.
// - Scale switch delayed zero to seven port clocks.
// - Port takes 14-bit mantissa, 3-bit exponent, qualifier.
// - Ports A,B on first clock, C,D second.
// - Exponent adjusted by selected scale before filter.
// - Invert set shifts left as exponent grows.
// - Inverted shift is mod(7-exp+scale, 32).
`timescale 1ns/100ps

module ilg_gain_switch
  import ilg_pkg::*;
#(
  parameter int DWELL_W = 16,
  parameter int OUT_W   = 24
) (
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire logic                             ce,
  input  wire logic                             port_ab_clock,
  input  wire logic                             port_cd_clock,
  input  wire logic [NPORT-1:0][MANT_W-1:0]     mantissa,
  input  wire logic [NPORT-1:0][EXP_W-1:0]      exponent,
  input  wire logic [NPORT-1:0]                 input_qualifier,
  input  wire logic [ADDR_W-1:0]                reg_addr,
  input  wire logic [DATA_W-1:0]                reg_wdata,
  input  wire logic                             reg_write,
  input  wire logic                             reg_read,
  output logic      [DATA_W-1:0]                reg_rdata,
  output logic      [NPORT-1:0]                 level_flag_primary,
  output logic      [NPORT-1:0]                 level_flag_secondary,
  output logic      [NPORT-1:0][OUT_W-1:0]      scaled_data,
  output logic      [NPORT-1:0]                 scaled_valid
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [MANT_W-1:0] mag_of(input logic [MANT_W-1:0] m);
    mag_of = m[MANT_W-1] ? MANT_W'(~m + 1'b1) : m;
  endfunction

  function automatic logic [SHIFT_W-1:0] shift_of(input logic [EXP_W-1:0] e,
                                                  input logic             inv,
                                                  input logic [SCALE_W-1:0] sc);
    logic [EXP_W-1:0] ee;
    ee       = inv ? EXP_MAX - e : e;
    shift_of = SHIFT_W'({2'b00, ee} + sc);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_LEN-1:0] ab_sync_q;
  logic [SYNC_LEN-1:0] cd_sync_q;
  logic                ab_lvl_q;
  logic                cd_lvl_q;
  logic [SYNC_LEN-1:0] qual_sync_q [NPORT];
  logic [NPORT-1:0]    qual_lvl_q;
  logic [MANT_W-1:0]   mant_sync_q [NPORT][SYNC_LEN];
  logic [EXP_W-1:0]    exp_sync_q  [NPORT][SYNC_LEN];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ab_sync_q <= '0;
      cd_sync_q <= '0;
      ab_lvl_q  <= 1'b0;
      cd_lvl_q  <= 1'b0;
    end else if (ce) begin
      ab_sync_q <= {ab_sync_q[SYNC_LEN-2:0], port_ab_clock};
      cd_sync_q <= {cd_sync_q[SYNC_LEN-2:0], port_cd_clock};
      if (ab_sync_q[1] == ab_sync_q[2]) ab_lvl_q <= ab_sync_q[2];
      if (cd_sync_q[1] == cd_sync_q[2]) cd_lvl_q <= cd_sync_q[2];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NPORT; p++) begin
        qual_sync_q[p] <= '0;
        qual_lvl_q[p]  <= 1'b0;
        for (int s = 0; s < SYNC_LEN; s++) begin
          mant_sync_q[p][s] <= '0;
          exp_sync_q[p][s]  <= '0;
        end
      end
    end else if (ce) begin
      for (int p = 0; p < NPORT; p++) begin
        qual_sync_q[p]    <= {qual_sync_q[p][SYNC_LEN-2:0], input_qualifier[p]};
        mant_sync_q[p][0] <= mantissa[p];
        exp_sync_q[p][0]  <= exponent[p];
        for (int s = 1; s < SYNC_LEN; s++) begin
          mant_sync_q[p][s] <= mant_sync_q[p][s-1];
          exp_sync_q[p][s]  <= exp_sync_q[p][s-1];
        end
        if (qual_sync_q[p][1] == qual_sync_q[p][2]) qual_lvl_q[p] <= qual_sync_q[p][2];
      end
    end
  end

  // Each port samples on the rising edge of its own port clock.
  logic             ab_rise;
  logic             cd_rise;
  logic [NPORT-1:0] port_stb;

  assign ab_rise = ab_sync_q[1] & ab_sync_q[2] & ~ab_lvl_q;
  assign cd_rise = cd_sync_q[1] & cd_sync_q[2] & ~cd_lvl_q;
  assign port_stb = {cd_rise, cd_rise, ab_rise, ab_rise};

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [2*SCALE_W-1:0] scale_q [NPORT];
  logic [NPORT-1:0]     inv_q;
  logic [NPORT-1:0]     ilv_q;
  logic [DLY_W-1:0]     dly_q   [NPORT];
  logic [MANT_W-1:0]    upper_q [NCIRC];
  logic [MANT_W-1:0]    lower_q [NCIRC];
  logic [DWELL_W-1:0]   dwell_q [NCIRC];

  logic [1:0]           acc_port;
  logic [OFF_W-1:0]     acc_off;

  assign acc_port = reg_addr[ADDR_W-1:OFF_W];
  assign acc_off  = reg_addr[OFF_W-1:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NPORT; p++) begin
        scale_q[p] <= RST_SCALE;
        inv_q[p]   <= 1'b0;
        ilv_q[p]   <= 1'b0;
        dly_q[p]   <= '0;
      end
      for (int c = 0; c < NCIRC; c++) begin
        upper_q[c] <= RST_UPPER;
        lower_q[c] <= RST_LOWER;
        dwell_q[c] <= '0;
      end
    end else if (ce && reg_write) begin
      case (acc_off)
        OFF_SCALE:   scale_q[acc_port] <= reg_wdata[2*SCALE_W-1:0];
        OFF_CTRL: begin
          inv_q[acc_port] <= reg_wdata[CTRL_INV_BIT];
          ilv_q[acc_port] <= reg_wdata[CTRL_ILV_BIT];
          dly_q[acc_port] <= reg_wdata[CTRL_DLY_LSB +: DLY_W];
        end
        OFF_UPPER_P: upper_q[{acc_port, 1'b0}] <= reg_wdata[MANT_W-1:0];
        OFF_LOWER_P: lower_q[{acc_port, 1'b0}] <= reg_wdata[MANT_W-1:0];
        OFF_DWELL_P: dwell_q[{acc_port, 1'b0}] <= reg_wdata[DWELL_W-1:0];
        OFF_UPPER_S: upper_q[{acc_port, 1'b1}] <= reg_wdata[MANT_W-1:0];
        OFF_LOWER_S: lower_q[{acc_port, 1'b1}] <= reg_wdata[MANT_W-1:0];
        OFF_DWELL_S: dwell_q[{acc_port, 1'b1}] <= reg_wdata[DWELL_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Gain control circuits
  // ----------------------------------------------------------------
  ilg_lvl_t           lvl_q  [NCIRC];
  logic [DWELL_W-1:0] cnt_q  [NCIRC];
  logic [NCIRC-1:0]   circ_en;
  logic [NCIRC-1:0]   active;
  logic [MANT_W-1:0]  circ_mag [NCIRC];

  // Even circuit sees qualifier-low samples, odd circuit qualifier-high ones.
  always_comb begin
    for (int c = 0; c < NCIRC; c++) begin
      if (c % 2 == 1) begin
        circ_en[c] = port_stb[c/2] & ilv_q[c/2] & qual_lvl_q[c/2];
      end else begin
        circ_en[c] = port_stb[c/2] & ~(ilv_q[c/2] & qual_lvl_q[c/2]);
      end
      circ_mag[c] = mag_of(mant_sync_q[c/2][SYNC_LEN-1]);
      active[c]   = (lvl_q[c] != ILG_QUIET);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < NCIRC; c++) begin
        lvl_q[c] <= ILG_QUIET;
        cnt_q[c] <= '0;
      end
    end else if (ce) begin
      for (int c = 0; c < NCIRC; c++) begin
        if (circ_en[c]) begin
          case (lvl_q[c])
            ILG_QUIET: begin
              if (circ_mag[c] >= upper_q[c]) lvl_q[c] <= ILG_HELD;
            end
            ILG_HELD: begin
              if (circ_mag[c] < lower_q[c]) begin
                if (dwell_q[c] <= DWELL_W'(1)) begin
                  lvl_q[c] <= ILG_QUIET;
                end else begin
                  lvl_q[c] <= ILG_DWELL;
                  cnt_q[c] <= DWELL_W'(dwell_q[c] - 1'b1);
                end
              end
            end
            ILG_DWELL: begin
              if (circ_mag[c] >= lower_q[c]) begin
                lvl_q[c] <= ILG_HELD;
                cnt_q[c] <= '0;
              end else if (cnt_q[c] == DWELL_W'(1)) begin
                lvl_q[c] <= ILG_QUIET;
                cnt_q[c] <= '0;
              end else begin
                cnt_q[c] <= DWELL_W'(cnt_q[c] - 1'b1);
              end
            end
            default: begin
              lvl_q[c] <= ILG_QUIET;
              cnt_q[c] <= '0;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicator outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_flag_primary   <= '0;
      level_flag_secondary <= '1;
    end else if (ce) begin
      for (int p = 0; p < NPORT; p++) begin
        level_flag_primary[p] <= active[2*p];
        if (ilv_q[p]) begin
          level_flag_secondary[p] <= active[2*p+1];
        end else begin
          level_flag_secondary[p] <= ~active[2*p];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Scale selection delay and exponent shifting
  // ----------------------------------------------------------------
  logic [HIST_LEN-1:0] hist_q [NPORT];
  logic [NPORT-1:0]    sel_now;
  logic [NPORT-1:0]    sel_dly;
  logic [SCALE_W-1:0]  scale_sel [NPORT];
  logic [SHIFT_W-1:0]  shift_amt [NPORT];

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      sel_now[p] = (ilv_q[p] & qual_lvl_q[p]) ? active[2*p+1] : active[2*p];
      if (dly_q[p] == '0) begin
        sel_dly[p] = sel_now[p];
      end else begin
        sel_dly[p] = hist_q[p][dly_q[p] - 1'b1];
      end
      scale_sel[p] = sel_dly[p] ? scale_q[p][SCALE_LOUD_LSB +: SCALE_W]
                                : scale_q[p][SCALE_QUIET_LSB +: SCALE_W];
      shift_amt[p] = shift_of(exp_sync_q[p][SYNC_LEN-1], inv_q[p], scale_sel[p]);
    end
  end

  // The delay line advances once per sample, so the delay is in port clocks.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NPORT; p++) hist_q[p] <= '0;
    end else if (ce) begin
      for (int p = 0; p < NPORT; p++) begin
        if (port_stb[p]) hist_q[p] <= {hist_q[p][HIST_LEN-2:0], sel_now[p]};
      end
    end
  end

  // Mantissa is left-aligned in a wider word so right shifts keep fraction bits.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scaled_data  <= '0;
      scaled_valid <= '0;
    end else if (ce) begin
      scaled_valid <= port_stb;
      for (int p = 0; p < NPORT; p++) begin
        if (port_stb[p]) begin
          scaled_data[p] <= OUT_W'($signed({mant_sync_q[p][SYNC_LEN-1], {(OUT_W-MANT_W){1'b0}}})
                                   >>> shift_amt[p]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_read) begin
        case (acc_off)
          OFF_SCALE:   reg_rdata <= DATA_W'(scale_q[acc_port]);
          OFF_CTRL:    reg_rdata <= DATA_W'({dly_q[acc_port], ilv_q[acc_port], inv_q[acc_port]});
          OFF_UPPER_P: reg_rdata <= DATA_W'(upper_q[{acc_port, 1'b0}]);
          OFF_LOWER_P: reg_rdata <= DATA_W'(lower_q[{acc_port, 1'b0}]);
          OFF_DWELL_P: reg_rdata <= DATA_W'(dwell_q[{acc_port, 1'b0}]);
          OFF_UPPER_S: reg_rdata <= DATA_W'(upper_q[{acc_port, 1'b1}]);
          OFF_LOWER_S: reg_rdata <= DATA_W'(lower_q[{acc_port, 1'b1}]);
          OFF_DWELL_S: reg_rdata <= DATA_W'(dwell_q[{acc_port, 1'b1}]);
          OFF_STATUS:  reg_rdata <= DATA_W'({lvl_q[{acc_port, 1'b1}], lvl_q[{acc_port, 1'b0}]});
          default:     reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule // ilg_gain_switch

// [verilog/ilg_pkg.sv]
// Constants, register map and types for the input level gain switch.
package ilg_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NPORT      = 4;
  localparam int NCIRC      = 8;
  localparam int MANT_W     = 14;
  localparam int EXP_W      = 3;
  localparam int SCALE_W    = 5;
  localparam int SHIFT_W    = 5;
  localparam int DLY_W      = 3;
  localparam int HIST_LEN   = 7;
  localparam int ADDR_W     = 10;
  localparam int DATA_W     = 32;
  localparam int OFF_W      = 8;
  localparam int SYNC_LEN   = 3;

  // ----------------------------------------------------------------
  // Register offsets, port select in address bits 9:8
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SCALE   = 8'h92;
  localparam logic [7:0] OFF_CTRL    = 8'h93;
  localparam logic [7:0] OFF_UPPER_P = 8'h94;
  localparam logic [7:0] OFF_LOWER_P = 8'h95;
  localparam logic [7:0] OFF_DWELL_P = 8'h96;
  localparam logic [7:0] OFF_UPPER_S = 8'h97;
  localparam logic [7:0] OFF_LOWER_S = 8'h98;
  localparam logic [7:0] OFF_DWELL_S = 8'h99;
  localparam logic [7:0] OFF_STATUS  = 8'h9A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCALE_LOUD_LSB  = 0;
  localparam int SCALE_QUIET_LSB = 5;
  localparam int CTRL_INV_BIT    = 0;
  localparam int CTRL_ILV_BIT    = 1;
  localparam int CTRL_DLY_LSB    = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed numbers
  // ----------------------------------------------------------------
  localparam logic [2*SCALE_W-1:0] RST_SCALE = 10'h000;
  localparam logic [MANT_W-1:0]    RST_UPPER = 14'h3FFF;
  localparam logic [MANT_W-1:0]    RST_LOWER = 14'h0000;
  localparam logic [EXP_W-1:0]     EXP_MAX   = 3'h7;

  typedef enum logic [1:0] {
    ILG_QUIET = 2'b00,
    ILG_HELD  = 2'b01,
    ILG_DWELL = 2'b10
  } ilg_lvl_t;

endpackage
